/* File: design/dkrt_pkg.sv */
// package: constants, modes and register map for the dual key reset timer
`default_nettype none
package dkrt_pkg;

  // clock and timebase
  localparam int unsigned CLK_HZ       = 100_000_000;  // pclk rate
  localparam int unsigned TICK_US      = 1000;         // slow timebase period in us
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_US;  // pclk cycles per tick

  // times in microseconds, as printed
  localparam int unsigned HOLD_SEL_LO_US = 7_500_000;   // select pin low
  localparam int unsigned HOLD_SEL_HI_US = 11_250_000;  // select pin high
  localparam int unsigned HOLD_STD_US    = 7_500_000;
  localparam int unsigned REL_STD_US     = 234_000;
  localparam int unsigned HOLD_ALT1_US   = 10_000_000;
  localparam int unsigned REL_ALT1_US    = 313_000;
  localparam int unsigned HOLD_ALT2_US   = 10_000_000;
  localparam int unsigned REL_ALT2_US    = 78_000;
  localparam int unsigned HOLD_ALT3_US   = 3_000_000;
  localparam int unsigned REL_ALT3_US    = 187_500;

  // tick counts: hold rounds up (least time), release rounds down (longest)
  localparam int unsigned TW = 16;  // tick counter width
  localparam logic [15:0] HOLD_SEL_LO_T = 16'((HOLD_SEL_LO_US + TICK_US - 1) / TICK_US);
  localparam logic [15:0] HOLD_SEL_HI_T = 16'((HOLD_SEL_HI_US + TICK_US - 1) / TICK_US);
  localparam logic [15:0] HOLD_STD_T    = 16'((HOLD_STD_US + TICK_US - 1) / TICK_US);
  localparam logic [15:0] REL_STD_T     = 16'(REL_STD_US / TICK_US);
  localparam logic [15:0] HOLD_ALT1_T   = 16'((HOLD_ALT1_US + TICK_US - 1) / TICK_US);
  localparam logic [15:0] REL_ALT1_T    = 16'(REL_ALT1_US / TICK_US);
  localparam logic [15:0] HOLD_ALT2_T   = 16'((HOLD_ALT2_US + TICK_US - 1) / TICK_US);
  localparam logic [15:0] REL_ALT2_T    = 16'(REL_ALT2_US / TICK_US);
  localparam logic [15:0] HOLD_ALT3_T   = 16'((HOLD_ALT3_US + TICK_US - 1) / TICK_US);
  localparam logic [15:0] REL_ALT3_T    = 16'(REL_ALT3_US / TICK_US);

  // delay option codes
  typedef enum logic [2:0] {
    DKRT_OPT_SELECT = 3'b000,  // selectable hold, release on key only
    DKRT_OPT_STD    = 3'b001,
    DKRT_OPT_ALT1   = 3'b010,
    DKRT_OPT_ALT2   = 3'b011,
    DKRT_OPT_ALT3   = 3'b100
  } dkrt_opt_type;

  // sequencer states
  typedef enum logic [1:0] {
    DKRT_IDLE   = 2'b00,  // waiting for both keys low
    DKRT_TIMING = 2'b01,  // hold timer running
    DKRT_ACTIVE = 2'b10,  // reset asserted
    DKRT_DONE   = 2'b11   // released, waiting for a key to rise
  } dkrt_state_type;

  // register offsets (byte addresses)
  localparam logic [11:0] CTRL_OFF   = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] COUNT_OFF  = 12'h008;

  // control field layout and reset
  localparam int unsigned CTRL_OPT_LSB = 0;  // option select, 3 bits
  localparam int unsigned CTRL_EN_BIT  = 4;  // timer enable
  localparam logic [31:0] CTRL_RST     = 32'h0000_0011;  // enabled, standard option

  // status field layout
  localparam int unsigned ST_STATE_LSB = 0;  // 2 bits
  localparam int unsigned ST_KEYS_LSB  = 2;  // synced keys, 2 bits
  localparam int unsigned ST_RST_BIT   = 4;  // reset asserted
  localparam int unsigned ST_SEL_BIT   = 5;  // delay select level

  // apb request carrier
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } dkrt_apb_req_type;

endpackage : dkrt_pkg
`default_nettype wire

/* File: design/dkrt_top.sv */
// dual key reset timer: key synchroniser, tick divider, sequencer, apb registers
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module dkrt_top #(
  parameter int unsigned TICK_CYCLES = dkrt_pkg::TICK_CYCLES  // shorten for simulation
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        key_in_a_n,
  input  wire logic        key_in_b_n,
  input  wire logic        delay_sel,
  output logic             reset_out_n_o,
  output logic             reset_out_n_oe,
  output logic             reset_out_high
);

  // the divider needs a count of two or more to make a one-cycle tick
  if (TICK_CYCLES < 2) begin : g_tick_check
    $error("TICK_CYCLES must be at least 2");
  end

  dkrt_pkg::dkrt_apb_req_type req;      // bundled bus request
  logic [31:0]                ctrl_q;   // control register
  logic [1:0]                 key_s1_q; // first sync stage, read only by stage two
  logic [1:0]                 key_s2_q; // synchronised keys, low = pressed
  logic                       sel_s1_q; // select pin first stage
  logic                       sel_s2_q; // select pin synchronised
  logic [31:0]                div_q;    // tick divider
  logic                       tick;     // one-cycle slow timebase enable
  logic [15:0]                cnt_q;    // tick counter
  dkrt_pkg::dkrt_state_type   state_q;  // sequencer state
  logic                       rst_act;  // reset asserted
  logic                       both_low; // both keys pressed
  dkrt_pkg::dkrt_opt_type     opt;      // selected option
  logic [15:0]                hold_t;   // hold limit in ticks
  logic [15:0]                rel_t;    // release limit in ticks
  logic                       bus_wr;   // write access phase
  logic                       addr_ok;  // mapped address

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

  // keys and select pin come from outside: two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_s1_q <= 2'h3;
      key_s2_q <= 2'h3;
      sel_s1_q <= 1'b0;
      sel_s2_q <= 1'b0;
    end else begin
      key_s1_q <= {key_in_b_n, key_in_a_n};
      key_s2_q <= key_s1_q;
      sel_s1_q <= delay_sel;
      sel_s2_q <= sel_s1_q;
    end
  end

  // slow timebase divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 32'h0;
    end else if (tick) begin
      div_q <= 32'h0;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end

  assign tick     = (div_q == 32'(TICK_CYCLES - 1));
  assign both_low = (key_s2_q == 2'h0);  // keys judged only on synced copies
  assign opt      = dkrt_pkg::dkrt_opt_type'(ctrl_q[dkrt_pkg::CTRL_OPT_LSB +: 3]);

  // hold and release limits per option
  always_comb begin
    hold_t = dkrt_pkg::HOLD_STD_T;
    rel_t  = dkrt_pkg::REL_STD_T;
    unique case (opt)
      dkrt_pkg::DKRT_OPT_SELECT: begin
        // pin level is assumed static while powered, so no re-evaluation guard
        hold_t = sel_s2_q ? dkrt_pkg::HOLD_SEL_HI_T : dkrt_pkg::HOLD_SEL_LO_T;
        rel_t  = 16'h0;  // unused: no auto release
      end
      dkrt_pkg::DKRT_OPT_STD: begin
        hold_t = dkrt_pkg::HOLD_STD_T;
        rel_t  = dkrt_pkg::REL_STD_T;
      end
      dkrt_pkg::DKRT_OPT_ALT1: begin
        hold_t = dkrt_pkg::HOLD_ALT1_T;
        rel_t  = dkrt_pkg::REL_ALT1_T;
      end
      dkrt_pkg::DKRT_OPT_ALT2: begin
        hold_t = dkrt_pkg::HOLD_ALT2_T;
        rel_t  = dkrt_pkg::REL_ALT2_T;
      end
      dkrt_pkg::DKRT_OPT_ALT3: begin
        hold_t = dkrt_pkg::HOLD_ALT3_T;
        rel_t  = dkrt_pkg::REL_ALT3_T;
      end
      default: begin
        // unused codes fall back to the standard option
        hold_t = dkrt_pkg::HOLD_STD_T;
        rel_t  = dkrt_pkg::REL_STD_T;
      end
    endcase
  end

  // sequencer; a single tied-low key simply reads as pressed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= dkrt_pkg::DKRT_IDLE;
      cnt_q   <= 16'h0;
    end else if (!ctrl_q[dkrt_pkg::CTRL_EN_BIT]) begin
      // disabled: drop everything, outputs released
      state_q <= dkrt_pkg::DKRT_IDLE;
      cnt_q   <= 16'h0;
    end else if (tick) begin
      // all four state codes are legal, so no default branch
      unique case (state_q)
        dkrt_pkg::DKRT_IDLE: begin
          cnt_q <= 16'h0;
          if (both_low) begin
            state_q <= dkrt_pkg::DKRT_TIMING;
          end
        end
        dkrt_pkg::DKRT_TIMING: begin
          if (!both_low) begin
            state_q <= dkrt_pkg::DKRT_IDLE;  // abort, next try starts at zero
            cnt_q   <= 16'h0;
          end else if (cnt_q + 16'h1 >= hold_t) begin
            state_q <= dkrt_pkg::DKRT_ACTIVE;
            cnt_q   <= 16'h0;
          end else begin
            cnt_q <= cnt_q + 16'h1;
          end
        end
        dkrt_pkg::DKRT_ACTIVE: begin
          if (!both_low) begin
            state_q <= dkrt_pkg::DKRT_IDLE;  // key release ends reset
            cnt_q   <= 16'h0;
          end else if (opt != dkrt_pkg::DKRT_OPT_SELECT && cnt_q + 16'h1 >= rel_t) begin
            state_q <= dkrt_pkg::DKRT_DONE;  // automatic release
            cnt_q   <= 16'h0;
          end else if (opt != dkrt_pkg::DKRT_OPT_SELECT) begin
            cnt_q <= cnt_q + 16'h1;
          end
        end
        dkrt_pkg::DKRT_DONE: begin
          if (!both_low) begin
            state_q <= dkrt_pkg::DKRT_IDLE;  // re-arm only after a key rises
          end
        end
      endcase
    end
  end

  assign rst_act = (state_q == dkrt_pkg::DKRT_ACTIVE);

  // pin drivers from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_out_n_oe <= 1'b0;
      reset_out_high <= 1'b0;
    end else begin
      reset_out_n_oe <= rst_act;  // pulls low only, released otherwise
      reset_out_high <= rst_act;  // push-pull mirror
    end
  end

  assign reset_out_n_o = 1'b0;  // open drain: drives low when enabled

  // apb slave, zero wait states
  assign pready  = 1'b1;
  assign addr_ok = (req.addr == dkrt_pkg::CTRL_OFF) || (req.addr == dkrt_pkg::STATUS_OFF) ||
                   (req.addr == dkrt_pkg::COUNT_OFF);
  assign pslverr = req.sel && req.enable && !addr_ok;
  assign bus_wr  = req.sel && req.enable && req.write;

  // control register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= dkrt_pkg::CTRL_RST;
    end else if (bus_wr && req.addr == dkrt_pkg::CTRL_OFF) begin
      ctrl_q <= req.wdata & 32'h0000_0017;  // only option and enable bits kept
    end
  end

  // read data registered at setup so it is stable in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (req.sel && !req.enable && !req.write) begin
      unique case (req.addr)
        dkrt_pkg::CTRL_OFF:   prdata <= ctrl_q;
        dkrt_pkg::STATUS_OFF: prdata <= {26'h0, sel_s2_q, rst_act, key_s2_q, state_q};
        dkrt_pkg::COUNT_OFF:  prdata <= {16'h0, cnt_q};
        default:              prdata <= 32'h0;
      endcase
    end
  end

endmodule : dkrt_top
`default_nettype wire

/* File: tb/dkrt_top_sva.sv */
// checker: port-level properties of the dual key reset timer
`timescale 1ns/1ps
`default_nettype none
module dkrt_top_sva #(
  parameter int unsigned TICK_CYCLES = 4  // pclk cycles per tick
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        key_in_a_n,
  input wire logic        key_in_b_n,
  input wire logic        delay_sel,
  input wire logic        reset_out_n_o,
  input wire logic        reset_out_n_oe,
  input wire logic        reset_out_high
);
  localparam int unsigned MIN_HOLD = 3000 * TICK_CYCLES;  // shortest hold over all options
  logic [31:0] low_q;  // cycles with both keys pressed
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // press length counter; raw keys lead the synced view, so this never undercounts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_q <= 32'h0;
    else low_q <= (key_in_a_n || key_in_b_n) ? 32'h0 : low_q + 32'h1;
  end
  chk_oe_high: assert property (reset_out_n_oe == reset_out_high)
    else $error("open drain enable and high output disagree");
  chk_od_low: assert property (reset_out_n_oe |-> reset_out_n_o == 1'b0)
    else $error("open drain pin driven high");
  chk_ready_now: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  chk_err_unmapped: assert property (psel && penable && paddr >= 12'h00c |-> pslverr)
    else $error("unmapped access not flagged");
  chk_ok_mapped: assert property (psel && penable && paddr inside {12'h000, 12'h004, 12'h008} |-> !pslverr)
    else $error("mapped access flagged");
  chk_rd_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside a setup cycle");
  chk_key_up: assert property ((key_in_a_n || key_in_b_n) [*8] |-> !reset_out_high)
    else $error("reset held with a key released");
  chk_hold_min: assert property ($rose(reset_out_high) |-> low_q >= MIN_HOLD)
    else $error("reset asserted before the hold time");
  cover property ($rose(reset_out_high));
  cover property ($fell(reset_out_high) && !key_in_a_n && !key_in_b_n);
  cover property (psel && penable && pslverr);
endmodule : dkrt_top_sva
`default_nettype wire

/* File: tb/dkrt_keys.sv */
// partner model: two push keys with pull-ups and the host reset input
`timescale 1ns/1ps
`default_nettype none
module dkrt_keys (
  input wire logic press_a,        // key a held down
  input wire logic press_b,        // key b held down
  input wire logic reset_out_n_o,  // open drain data
  input wire logic reset_out_n_oe, // open drain enable
  output logic     key_in_a_n,
  output logic     key_in_b_n,
  output logic     host_rst_n      // level the host sees
);
  // released key floats to its pull-up; an unused key would be strapped low
  assign key_in_a_n = !press_a;
  assign key_in_b_n = !press_b;
  // pulled up unless the device sinks the line
  assign host_rst_n = reset_out_n_oe ? reset_out_n_o : 1'b1;
endmodule : dkrt_keys
`default_nettype wire

/* File: tb/tb_top.sv */
// testbench: apb setup, timed key presses, release checks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned TC = 2;  // shortened tick, leaves room for every option in the cycle budget
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, ka, kb, o, oe, rh, host_rst_n, press_a = 1'b0, press_b = 1'b0;
  logic delay_sel = 1'b0;  // strap, moved only while reset holds the block
  int err_total = 0, tests_run = 0, cyc = 0, n;
  always #5 pclk = ~pclk;
  dkrt_top #(.TICK_CYCLES(TC)) i_dkrt_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_in_a_n(ka), .key_in_b_n(kb), .delay_sel(delay_sel), .reset_out_n_o(o), .reset_out_n_oe(oe),
    .reset_out_high(rh));
  dkrt_keys i_dkrt_keys (.press_a(press_a), .press_b(press_b), .reset_out_n_o(o), .reset_out_n_oe(oe),
    .key_in_a_n(ka), .key_in_b_n(kb), .host_rst_n(host_rst_n));
  task automatic stop_test();
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // one apb transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk); psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // cycles until the high output reaches level v
  task automatic wait_rh(input logic v);
    n = 0;
    do begin @(posedge pclk); #1; n++; end while (rh !== v && n < 60000);
  endtask : wait_rh
  function automatic logic in_win(input int cnt, input int ticks);
    return cnt >= ticks * TC && cnt <= ticks * TC + TC + 8;
  endfunction : in_win
  task automatic press_both(input int hold);
    @(posedge pclk); press_a <= 1'b1; press_b <= 1'b1;
    wait_rh(1'b1);
    check("hold time", 1, in_win(n, hold));
    check("host pin", 0, host_rst_n);
  endtask : press_both
  task automatic let_go();
    @(posedge pclk); press_a <= 1'b0; press_b <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask : let_go
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 100000) begin err_total++; stop_test(); end
  end
  initial begin
    void'($urandom(32'h02e4));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0); check("ctrl reset", 32'h11, q);
    apb(1'b0, 12'h00c, 32'h0); check("unmapped err", 1, e);
    // standard: full hold, automatic release, no second assertion
    press_both(7500);
    wait_rh(1'b0); check("auto release", 1, in_win(n, 234));
    repeat (400) @(posedge pclk);
    check("no reassert", 0, rh);
    let_go();
    // long alternate, stray reserved bits must not stick; a short press aborts
    apb(1'b1, 12'h000, 32'h12 | ($urandom & 32'hffff_ffe8));
    apb(1'b0, 12'h000, 32'h0); check("ctrl option", 32'h12, q);
    @(posedge pclk); press_a <= 1'b1; press_b <= 1'b1;
    repeat ($urandom % 2500 + 100) @(posedge pclk);
    check("aborted", 0, rh);
    let_go();
    // short alternate: the new press must time a full hold from zero
    apb(1'b1, 12'h000, 32'h14);
    press_both(3000);
    repeat ($urandom % 500 + 10) @(posedge pclk);
    press_a <= 1'b0;
    wait_rh(1'b0); check("early release", 1, n <= 8);
    let_go();
    // selectable option with the strap low
    apb(1'b1, 12'h000, 32'h10);
    press_both(7500);
    repeat (1600) @(posedge pclk);
    check("still held", 1, rh);
    press_b <= 1'b0;
    wait_rh(1'b0); check("key release", 1, n <= 8);
    let_go();
    // power cycle: the strap moves high only while the block is held in reset
    presetn <= 1'b0;
    delay_sel <= 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    check("ctrl reset again", 32'h11, q);
    // selectable option with the strap high: longer hold, status shows it
    apb(1'b1, 12'h000, 32'h10);
    press_both(11250);
    apb(1'b0, 12'h004, 32'h0);
    check("status held", 32'h32, q);
    let_go();
    // second long alternate: full hold, then the shortest automatic release
    apb(1'b1, 12'h000, 32'h13);
    press_both(10000);
    wait_rh(1'b0);
    check("alt release", 1, in_win(n, 78));
    let_go();
    stop_test();
  end
endmodule : tb_top
bind dkrt_top dkrt_top_sva #(.TICK_CYCLES(TICK_CYCLES)) i_dkrt_top_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .key_in_a_n(key_in_a_n), .key_in_b_n(key_in_b_n),
  .delay_sel(delay_sel), .reset_out_n_o(reset_out_n_o), .reset_out_n_oe(reset_out_n_oe),
  .reset_out_high(reset_out_high));
`default_nettype wire
